// file: design/cmb_pkg.sv
package cmb_pkg;
   localparam int NF = 16;
   localparam int NRX = 8;
   localparam int NTX = 9;
   localparam int NPROG = 6;
   localparam int NDED = 2;
   localparam int MSG_W = 104;
   localparam int RXI_W = 3;
   localparam int TXI_W = 4;
   localparam int HIT_W = 5;
   localparam int ASC_W = 4;
   typedef enum logic [1:0] {
      CMB_LEGACY = 2'h0,
      CMB_ENH = 2'h1,
      CMB_FIFO = 2'h3
   } cmb_mode_t;
   typedef enum logic {
      TX_IDLE = 1'h0,
      TX_SEND = 1'h1
   } cmb_tx_state_t;
   localparam logic [1:0] RMODE_FILT = 2'h0;
   localparam logic [1:0] RMODE_STD = 2'h1;
   localparam logic [1:0] RMODE_EXT = 2'h2;
   localparam logic [1:0] RMODE_ANY = 2'h3;
   localparam int RMODE_ALL_BIT = 1;
   localparam logic [NF-1:0] LEG_B0_FILT = 16'h0003;
   localparam logic [NF-1:0] LEG_B1_FILT = 16'h003c;
   localparam logic [4:0] ICODE_FIFO = 5'h10;
   localparam logic [4:0] ICODE_RST = 5'h00;
   localparam logic [3:0] CAP_MODE_CAN = 4'h3;
   localparam logic [RXI_W-1:0] FIFO_HEAD = 3'h0;
   localparam logic [RXI_W-1:0] FIFO_MIN_LAST = 3'h1;
   localparam logic [3:0] WM_FEW = 4'h1;
   localparam logic [3:0] WM_MANY = 4'h4;
   typedef struct packed {
      logic err;
      logic rtr;
      logic ext;
      logic [NF-1:0] hits;
      logic [MSG_W-1:0] body;
   } cmb_msg_t;
endpackage

// file: design/cmb_stream_if.sv
`timescale 1ns/1ns
interface cmb_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface // cmb_stream_if

// file: design/cmb_skid.sv
`timescale 1ns/1ns
module cmb_skid #(parameter int W = 8, parameter int DEPTH = 2) (
   input wire logic clk_sys,
   input wire logic rst,
   cmb_stream_if.sink s_in,
   cmb_stream_if.source s_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [CW-1:0] cnt_q;
   logic push, pop;

   assign s_in.ready = (cnt_q != CW'(DEPTH));
   assign s_out.valid = (cnt_q != '0);
   assign s_out.data = mem_q[rp_q];
   assign push = s_in.valid & s_in.ready;
   assign pop = s_out.valid & s_out.ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wp_q] <= s_in.data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
         end
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end
endmodule // cmb_skid

// file: design/cmb_tx_pick.sv
`timescale 1ns/1ns
module cmb_tx_pick #(parameter int N = 9, parameter int IW = 4) (
   input wire logic [N-1:0] req,
   input wire logic [N-1:0][1:0] prio,
   output logic found,
   output logic [IW-1:0] idx
);
   logic [1:0] best;

   // Ascending scan with >= lets the higher buffer number win a tie
   always_comb begin
      found = 1'b0;
      idx = '0;
      best = '0;
      for (int i = 0; i < N; i++) begin
         if (req[i] && (!found || prio[i] >= best)) begin
            found = 1'b1;
            idx = IW'(i);
            best = prio[i];
         end
      end
   end
endmodule // cmb_tx_pick

// file: design/cmb_msgbuf.sv
`timescale 1ns/1ns
module cmb_msgbuf
   import cmb_pkg::*;
#(
   parameter int SKID_DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire cmb_mode_t op_mode,
   input wire logic [NTX-1:0] tx_request_flag,
   input wire logic [NTX-1:0][1:0] tx_priority_field,
   input wire logic [NPROG-1:0] prog_tx_enable,
   input wire logic bus_idle,
   input wire logic tx_done,
   output logic tx_start,
   output logic [TXI_W-1:0] tx_buffer_sel,
   output logic tx_busy,
   input wire logic asm_valid,
   output logic asm_ready,
   input wire logic [MSG_W-1:0] asm_body,
   input wire logic asm_ident_ext,
   input wire logic asm_rtr,
   input wire logic asm_error,
   input wire logic [NF-1:0] filter_match,
   input wire logic [NF-1:0] filter_enable,
   input wire logic [NF-1:0] filter_extended_enable,
   input wire logic [NF-1:0] mask_ident_type,
   input wire logic [NF-1:0][ASC_W-1:0] filter_buffer_assoc,
   input wire logic [NRX-1:0][1:0] receive_mode_field,
   input wire logic rollover_enable,
   input wire logic rx_int_enable,
   input wire logic fifo_watermark_select,
   input wire logic fw_hold,
   input wire logic clr_full,
   input wire logic [RXI_W-1:0] clr_idx,
   input wire logic [RXI_W-1:0] rd_idx,
   output logic [NRX-1:0] rx_buffer_full_flag,
   output logic [MSG_W-1:0] rd_body,
   output logic [HIT_W-1:0] rd_filter_hit,
   output logic rd_rtr,
   output logic rd_ident_type,
   output logic rx_irq,
   output logic rx_overflow,
   output logic fifo_wm_irq,
   output logic [4:0] interrupt_code_field,
   output logic [3:0] fifo_read_pointer,
   input wire logic timestamp_capture_enable,
   input wire logic [3:0] capture_unit_mode,
   input wire logic capture_pin,
   output logic capture_trigger,
   output logic capture_input
);
   cmb_stream_if #(.W($bits(cmb_msg_t))) s_in ();
   cmb_stream_if #(.W($bits(cmb_msg_t))) s_out ();
   cmb_msg_t hd;
   logic [NRX-1:0] full_q, is_tx, cand;
   logic [MSG_W-1:0] msg_q [NRX];
   logic [HIT_W-1:0] hit_q [NRX];
   logic [NRX-1:0] rtr_q, ext_q;
   logic [NF-1:0] okf;
   logic ld_ok, ld_fire, ovf, discard, roll;
   logic [RXI_W-1:0] ld_idx, wr_q, rd_q, fifo_last;
   logic [HIT_W-1:0] ld_hit;
   logic [3:0] fill, free_cnt;
   logic [4:0] icode_q;
   logic rx_irq_q, ovf_q, wm_q, cap_q;
   logic tx_found, tx_go, tx_start_q, tx_better;
   logic [TXI_W-1:0] tx_idx, tx_sel_q;
   logic [NTX-1:0] tx_req_m;
   cmb_tx_state_t tx_state_q;

   function automatic logic [HIT_W-1:0] low_filt(input logic [NF-1:0] v);
      low_filt = '0;
      for (int i = NF - 1; i >= 0; i--) begin
         if (v[i]) low_filt = HIT_W'(i);
      end
   endfunction

   function automatic logic rm_ok(input logic [1:0] rm, input logic ext);
      case (rm)
         RMODE_STD: rm_ok = !ext;
         RMODE_EXT: rm_ok = ext;
         default: rm_ok = 1'b1;
      endcase
   endfunction

   // Assembly side never waits on a full receive buffer; only fw_hold stalls it
   assign s_in.valid = asm_valid;
   assign s_in.data = cmb_msg_t'{err: asm_error, rtr: asm_rtr, ext: asm_ident_ext,
                                 hits: filter_match, body: asm_body};
   assign asm_ready = s_in.ready;
   assign s_out.ready = !fw_hold;
   assign hd = s_out.data;

   cmb_skid #(.W($bits(cmb_msg_t)), .DEPTH(SKID_DEPTH)) u_skid (
      .clk_sys(clk_sys),
      .rst(rst),
      .s_in(s_in),
      .s_out(s_out)
   );

   // FIFO ends before the first programmable buffer set to transmit
   always_comb begin
      logic stop;
      stop = 1'b0;
      fifo_last = FIFO_MIN_LAST;
      is_tx = '0;
      for (int p = 0; p < NPROG; p++) begin
         is_tx[p + NDED] = prog_tx_enable[p];
         if (prog_tx_enable[p]) stop = 1'b1;
         if (!stop) fifo_last = fifo_last + RXI_W'(1);
      end
   end

   always_comb begin
      fill = '0;
      for (int b = 0; b < NRX; b++) begin
         if (RXI_W'(b) <= fifo_last) fill = fill + 4'(full_q[b]);
      end
      free_cnt = 4'(fifo_last) + 4'h1 - fill;
   end

   // Acceptance and target selection
   always_comb begin
      ld_ok = 1'b0;
      ld_idx = '0;
      ld_hit = '0;
      ovf = 1'b0;
      discard = 1'b0;
      roll = 1'b0;
      cand = '0;
      for (int f = 0; f < NF; f++) begin
         if (op_mode == CMB_LEGACY) begin
            okf[f] = hd.hits[f] & (filter_extended_enable[f] == hd.ext) & !hd.err;
         end else begin
            okf[f] = filter_enable[f] & hd.hits[f] & !hd.err &
                     (!mask_ident_type[f] | (filter_extended_enable[f] == hd.ext));
         end
      end
      unique case (op_mode)
         CMB_LEGACY: begin
            cand[0] = (receive_mode_field[0] == RMODE_ANY) |
                      ((|(okf & LEG_B0_FILT)) & rm_ok(receive_mode_field[0], hd.ext));
            cand[1] = (receive_mode_field[1] == RMODE_ANY) |
                      ((|(okf & LEG_B1_FILT)) & rm_ok(receive_mode_field[1], hd.ext));
            if (cand[0]) begin
               ld_hit = low_filt(okf & LEG_B0_FILT);
               if (!full_q[0]) begin
                  ld_ok = 1'b1;
               end else if (rollover_enable && !full_q[1]) begin
                  ld_ok = 1'b1;
                  roll = 1'b1;
                  ld_idx = RXI_W'(1);
               end else begin
                  ovf = 1'b1;
               end
            end else if (cand[1]) begin
               ld_hit = low_filt(okf & LEG_B1_FILT);
               ld_idx = RXI_W'(1);
               ld_ok = !full_q[1];
               ovf = full_q[1];
            end
         end
         CMB_FIFO: begin
            if ((|okf) || receive_mode_field[0][RMODE_ALL_BIT]) begin
               ld_hit = low_filt(okf);
               ld_idx = wr_q;
               ld_ok = !full_q[wr_q];
               ovf = full_q[wr_q];
            end
         end
         CMB_ENH: begin
            for (int f = 0; f < NF; f++) begin
               if (okf[f] && filter_buffer_assoc[f] < ASC_W'(NRX)) begin
                  if (is_tx[filter_buffer_assoc[f][RXI_W-1:0]]) begin
                     discard = 1'b1;
                  end else begin
                     cand[filter_buffer_assoc[f][RXI_W-1:0]] = 1'b1;
                  end
               end
            end
            for (int b = 0; b < NRX; b++) begin
               if (!is_tx[b] && receive_mode_field[b][RMODE_ALL_BIT]) cand[b] = 1'b1;
            end
            for (int b = NRX - 1; b >= 0; b--) begin
               if (cand[b]) ld_idx = RXI_W'(b);
            end
            for (int f = NF - 1; f >= 0; f--) begin
               if (okf[f] && filter_buffer_assoc[f] == ASC_W'(ld_idx)) ld_hit = HIT_W'(f);
            end
            if ((|cand) && !discard) begin
               ld_ok = !full_q[ld_idx];
               ovf = full_q[ld_idx];
            end
         end
      endcase
   end

   assign ld_fire = s_out.valid & s_out.ready & ld_ok;

   // Set wins over a firmware clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         full_q <= '0;
      end else begin
         for (int b = 0; b < NRX; b++) begin
            if (ld_fire && ld_idx == RXI_W'(b)) begin
               full_q[b] <= 1'b1;
            end else if (clr_full && clr_idx == RXI_W'(b)) begin
               full_q[b] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ld_fire) begin
         msg_q[ld_idx] <= hd.body;
         hit_q[ld_idx] <= ld_hit;
         rtr_q[ld_idx] <= hd.rtr;
         ext_q[ld_idx] <= hd.ext;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_body <= '0;
         rd_filter_hit <= '0;
         rd_rtr <= 1'b0;
         rd_ident_type <= 1'b0;
      end else begin
         rd_body <= msg_q[rd_idx];
         rd_filter_hit <= hit_q[rd_idx];
         rd_rtr <= rtr_q[rd_idx];
         rd_ident_type <= ext_q[rd_idx];
      end
   end

   // Pointers reset to the head whenever FIFO mode is off
   always_ff @(posedge clk_sys) begin
      if (rst || op_mode != CMB_FIFO) begin
         wr_q <= FIFO_HEAD;
         rd_q <= FIFO_HEAD;
      end else begin
         if (ld_fire) begin
            wr_q <= (wr_q >= fifo_last) ? FIFO_HEAD : wr_q + RXI_W'(1);
         end
         if (clr_full && clr_idx == rd_q && full_q[rd_q]) begin
            rd_q <= (rd_q >= fifo_last) ? FIFO_HEAD : rd_q + RXI_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         icode_q <= ICODE_RST;
         rx_irq_q <= 1'b0;
         ovf_q <= 1'b0;
         wm_q <= 1'b0;
         cap_q <= 1'b0;
      end else begin
         if (ld_fire && op_mode == CMB_FIFO) icode_q <= ICODE_FIFO;
         rx_irq_q <= ld_fire & rx_int_enable;
         ovf_q <= s_out.valid & s_out.ready & ovf;
         wm_q <= ld_fire && op_mode == CMB_FIFO &&
                 free_cnt == (fifo_watermark_select ? WM_FEW : WM_MANY) + 4'h1;
         cap_q <= ld_fire & timestamp_capture_enable &
                  (capture_unit_mode == CAP_MODE_CAN);
      end
   end

   assign rx_buffer_full_flag = full_q;
   assign rx_irq = rx_irq_q;
   assign rx_overflow = ovf_q;
   assign fifo_wm_irq = wm_q;
   assign interrupt_code_field = icode_q;
   assign fifo_read_pointer = 4'(rd_q);
   assign capture_trigger = cap_q;
   // Capture unit sees the receive event in place of its own pin
   assign capture_input = timestamp_capture_enable ? cap_q : capture_pin;

   // Transmit: programmable buffers only count when set to transmit
   assign tx_req_m = tx_request_flag & {prog_tx_enable, {(NTX - NPROG){1'b1}}};

   cmb_tx_pick #(.N(NTX), .IW(TXI_W)) u_pick (
      .req(tx_req_m),
      .prio(tx_priority_field),
      .found(tx_found),
      .idx(tx_idx)
   );

   assign tx_go = (tx_state_q == TX_IDLE) & bus_idle & tx_found;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_state_q <= TX_IDLE;
         tx_sel_q <= '0;
         tx_start_q <= 1'b0;
      end else begin
         tx_start_q <= tx_go;
         unique case (tx_state_q)
            TX_IDLE: begin
               if (tx_go) begin
                  tx_state_q <= TX_SEND;
                  tx_sel_q <= tx_idx;
               end
            end
            TX_SEND: begin
               if (tx_done) tx_state_q <= TX_IDLE;
            end
         endcase
      end
   end

   assign tx_start = tx_start_q;
   assign tx_buffer_sel = tx_sel_q;
   assign tx_busy = (tx_state_q == TX_SEND);

   always_comb begin
      tx_better = 1'b0;
      for (int j = 0; j < NTX; j++) begin
         if (tx_req_m[j] && (tx_priority_field[j] > tx_priority_field[tx_idx] ||
             (tx_priority_field[j] == tx_priority_field[tx_idx] && TXI_W'(j) > tx_idx)))
            tx_better = 1'b1;
      end
   end

   sequence s_load;
      ld_fire;
   endsequence
   sequence s_fifo_load;
      ld_fire && op_mode == CMB_FIFO;
   endsequence

   a_tx_pick_order: assert property (@(posedge clk_sys) disable iff (rst)
      tx_go |-> !tx_better) else $error("lower priority buffer selected");
   a_tx_bus_idle: assert property (@(posedge clk_sys) disable iff (rst)
      tx_start |-> $past(bus_idle) && tx_busy) else $error("transmit without idle bus");
   a_full_lockout: assert property (@(posedge clk_sys) disable iff (rst)
      s_load |-> !full_q[ld_idx]) else $error("load into full buffer");
   a_full_set: assert property (@(posedge clk_sys) disable iff (rst)
      s_load |=> full_q[$past(ld_idx)]) else $error("full flag not set");
   a_msg_copy: assert property (@(posedge clk_sys) disable iff (rst)
      s_load |=> msg_q[$past(ld_idx)] == $past(hd.body)) else $error("message not copied");
   a_rx_irq_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      s_load ##0 rx_int_enable |=> rx_irq ##1 !rx_irq || $past(ld_fire))
      else $error("receive interrupt missing");
   a_icode_fifo: assert property (@(posedge clk_sys) disable iff (rst)
      s_fifo_load |=> interrupt_code_field == ICODE_FIFO) else $error("code not 10000");
   a_ptr_wrap: assert property (@(posedge clk_sys) disable iff (rst)
      s_fifo_load ##0 wr_q == fifo_last |=> wr_q == FIFO_HEAD) else $error("no wrap");
   a_rptr_adv: assert property (@(posedge clk_sys) disable iff (rst)
      op_mode == CMB_FIFO && clr_full && clr_idx == rd_q && full_q[rd_q] |=>
      fifo_read_pointer != $past(fifo_read_pointer)) else $error("read pointer stuck");
   a_rollover_b1: assert property (@(posedge clk_sys) disable iff (rst)
      s_load ##0 roll ##0 !(clr_full && clr_idx == '0) |=> full_q[1] && full_q[0])
      else $error("rollover failed");
   a_cap_trig: assert property (@(posedge clk_sys) disable iff (rst)
      capture_trigger |-> $past(ld_fire) && $past(timestamp_capture_enable))
      else $error("stray capture trigger");
endmodule // cmb_msgbuf

// file: tb/cmb_can_node.sv
`timescale 1ns/1ns
module cmb_can_node
   import cmb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic asm_ready,
   input wire logic tx_start,
   output logic asm_valid,
   output logic [MSG_W-1:0] asm_body,
   output logic asm_ident_ext,
   output logic asm_rtr,
   output logic asm_error,
   output logic [NF-1:0] filter_match,
   output logic bus_idle,
   output logic tx_done
);
   int tx_len = 3;
   initial begin
      {asm_valid, asm_body, asm_ident_ext, asm_rtr, asm_error, filter_match} = '0;
      bus_idle = 1'b1;
      tx_done = 1'b0;
   end
   // A finished frame is held until taken at a ready edge
   task automatic send(input logic [MSG_W-1:0] b, input logic x, r, e,
         input logic [NF-1:0] m);
      @(negedge clk_sys);
      asm_valid = 1'b1;
      {asm_body, asm_ident_ext, asm_rtr, asm_error, filter_match} = {b, x, r, e, m};
      do @(posedge clk_sys); while (asm_ready !== 1'b1);
      @(negedge clk_sys);
      asm_valid = 1'b0;
      // Released lines show junk so a stale frame cannot pass
      {asm_body, asm_ident_ext, asm_rtr, asm_error, filter_match} = ~{b, x, r, e, m};
   endtask
   // Bus is busy for tx_len + 1 cycles per frame, prompt or slow
   always @(posedge clk_sys) begin
      if (tx_start === 1'b1) begin
         bus_idle <= 1'b0;
         repeat (tx_len) @(posedge clk_sys);
         tx_done <= 1'b1;
         @(posedge clk_sys);
         tx_done <= 1'b0;
         bus_idle <= 1'b1;
      end
   end
endmodule // cmb_can_node

// file: tb/tb_can_msg_buffer_rx_tx_priority.sv
`timescale 1ns/1ns
module tb_can_msg_buffer_rx_tx_priority
   import cmb_pkg::*;
;
   logic clk_sys, rst, bus_idle, tx_done, tx_start, tx_busy, asm_valid, asm_ready;
   logic asm_ident_ext, asm_rtr, asm_error, rollover_enable, rx_int_enable;
   logic fw_hold, clr_full, rd_rtr, rd_ident_type, rx_irq, rx_overflow, fifo_wm_irq;
   logic fifo_watermark_select, timestamp_capture_enable, capture_pin;
   logic capture_trigger, capture_input;
   cmb_mode_t op_mode;
   logic [NTX-1:0] tx_request_flag;
   logic [NTX-1:0][1:0] tx_priority_field;
   logic [NPROG-1:0] prog_tx_enable;
   logic [TXI_W-1:0] tx_buffer_sel;
   logic [MSG_W-1:0] asm_body, rd_body, last_b, old_b;
   logic [MSG_W-1:0] fb [3];
   logic [NF-1:0] filter_match, filter_enable, filter_extended_enable, mask_ident_type;
   logic [NF-1:0][ASC_W-1:0] filter_buffer_assoc;
   logic [NRX-1:0][1:0] receive_mode_field;
   logic [RXI_W-1:0] clr_idx, rd_idx;
   logic [NRX-1:0] rx_buffer_full_flag;
   logic [HIT_W-1:0] rd_filter_hit;
   logic [4:0] interrupt_code_field;
   logic [3:0] fifo_read_pointer, capture_unit_mode;
   int fail_count, checks_done, irq_n, ovf_n, wm_n, trig_n, exp_ld, e, w;

   cmb_msgbuf DUT (.clk_sys, .rst, .op_mode, .tx_request_flag, .tx_priority_field,
      .prog_tx_enable, .bus_idle, .tx_done, .tx_start, .tx_buffer_sel, .tx_busy,
      .asm_valid, .asm_ready, .asm_body, .asm_ident_ext, .asm_rtr, .asm_error,
      .filter_match, .filter_enable, .filter_extended_enable, .mask_ident_type,
      .filter_buffer_assoc, .receive_mode_field, .rollover_enable, .rx_int_enable,
      .fifo_watermark_select, .fw_hold, .clr_full, .clr_idx, .rd_idx,
      .rx_buffer_full_flag, .rd_body, .rd_filter_hit, .rd_rtr, .rd_ident_type, .rx_irq,
      .rx_overflow, .fifo_wm_irq, .interrupt_code_field, .fifo_read_pointer,
      .timestamp_capture_enable, .capture_unit_mode, .capture_pin, .capture_trigger,
      .capture_input);
   cmb_can_node node (.clk_sys, .asm_ready, .tx_start, .asm_valid, .asm_body,
      .asm_ident_ext, .asm_rtr, .asm_error, .filter_match, .bus_idle, .tx_done);

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      irq_n += int'(rx_irq === 1'b1);
      ovf_n += int'(rx_overflow === 1'b1);
      wm_n += int'(fifo_wm_irq === 1'b1);
      trig_n += int'(capture_trigger === 1'b1 && capture_input === 1'b1);
   end

   task automatic chk_v(input string n, input logic [7:0] x, input logic [7:0] g);
      checks_done++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic chk_b(input string n, input logic [MSG_W-1:0] x, g);
      checks_done++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic chk_n(input string n, input int x, g);
      checks_done++;
      if (g != x) begin
         fail_count++;
         $display("mismatch %s expected %0d seen %0d", n, x, g);
      end
   endtask
   task automatic print_verdict();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Highest level wins, ties go to the highest buffer number
   function automatic int pick(input logic [NTX-1:0] q, input logic [NTX-1:0][1:0] p,
         input logic [NPROG-1:0] te);
      int s;
      s = -1;
      for (int i = 0; i < NTX; i++)
         if (q[i] && (i < 3 || te[i-3]) && (s < 0 || p[i] >= p[s])) s = i;
      return s;
   endfunction
   task automatic view(input int b);
      @(negedge clk_sys);
      rd_idx = b[2:0];
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic clr(input int b);
      @(negedge clk_sys);
      clr_full = 1'b1;
      clr_idx = b[2:0];
      @(negedge clk_sys);
      clr_full = 1'b0;
   endtask
   // Buffer d < 0 means the frame must not land; hit 5'h1f means hit is not checked
   task automatic rxc(input int d, input logic x, r, er, input logic [NF-1:0] m,
         input logic [HIT_W-1:0] h);
      last_b = MSG_W'({$urandom, $urandom, $urandom, $urandom});
      node.send(last_b, x, r, er, m);
      repeat (4) @(negedge clk_sys);
      if (d >= 0) begin
         exp_ld++;
         view(d);
         chk_b("rx_body", last_b, rd_body);
         chk_v("rx_rtr", 8'(r), 8'(rd_rtr));
         chk_v("rx_idtype", 8'(x), 8'(rd_ident_type));
         if (h != 5'h1f) chk_v("rx_hit", 8'(h), 8'(rd_filter_hit));
      end
   endtask

   initial begin
      #400000;
      fail_count++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'ha372e6e3));
      {rst, fw_hold, clr_full, rollover_enable, timestamp_capture_enable, capture_pin} = 6'h20;
      {tx_request_flag, tx_priority_field, prog_tx_enable, clr_idx, rd_idx} = '0;
      {receive_mode_field, filter_extended_enable, mask_ident_type} = '0;
      {rx_int_enable, fifo_watermark_select, filter_enable, filter_buffer_assoc} = '1;
      op_mode = CMB_LEGACY;
      capture_unit_mode = CAP_MODE_CAN;
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      chk_v("reset_full", 8'h00, rx_buffer_full_flag);
      chk_v("reset_state", 8'h01, 8'({tx_busy, fifo_read_pointer, asm_ready}));
      chk_v("reset_icode", 8'h00, 8'(interrupt_code_field));
      for (int k = 0; k < 24; k++) begin
         @(negedge clk_sys);
         node.tx_len = $urandom_range(1, 6);
         {tx_priority_field, prog_tx_enable, tx_request_flag} = 33'({$urandom, $urandom});
         if (k == 0) tx_request_flag = '1;
         if (k == 1) tx_priority_field = '0;
         if (pick(tx_request_flag, tx_priority_field, prog_tx_enable) < 0)
            tx_request_flag[2] = 1'b1;
         e = pick(tx_request_flag, tx_priority_field, prog_tx_enable);
         w = 0;
         while (tx_start !== 1'b1 && w < 40) begin
            @(posedge clk_sys);
            #2;
            w++;
         end
         chk_v("tx_sel", 8'(e), 8'(tx_buffer_sel));
         chk_v("tx_busy", 8'h01, 8'(tx_busy));
         @(negedge clk_sys);
         tx_request_flag = '0;
         w = 0;
         while (tx_busy !== 1'b0 && w < 40) begin
            @(negedge clk_sys);
            w++;
         end
      end
      capture_pin = 1'b1;
      #1;
      chk_v("cap_in", 8'h01, 8'(capture_input));
      timestamp_capture_enable = 1'b1;
      rxc(1, 1'b0, 1'b1, 1'b0, 16'h0014, 5'd2);
      rxc(0, 1'b0, 1'b0, 1'b0, 16'h0003, 5'd0);
      chk_v("full", 8'h03, rx_buffer_full_flag);
      old_b = last_b;
      rxc(-1, 1'b0, 1'b0, 1'b0, 16'h0001, 5'h1f);
      chk_n("overflow", 1, ovf_n);
      view(0);
      chk_b("kept_body", old_b, rd_body);
      rollover_enable = 1'b1;
      clr(1);
      rxc(1, 1'b0, 1'b0, 1'b0, 16'h0002, 5'd1);
      chk_n("overflow", 1, ovf_n);
      clr(0);
      clr(1);
      receive_mode_field = {NRX{RMODE_STD}};
      filter_extended_enable = '1;
      rxc(-1, 1'b1, 1'b0, 1'b0, 16'h0001, 5'h1f);
      chk_v("full", 8'h00, rx_buffer_full_flag);
      receive_mode_field = {NRX{RMODE_EXT}};
      rxc(0, 1'b1, 1'b0, 1'b0, 16'h0001, 5'd0);
      clr(0);
      receive_mode_field = {NRX{RMODE_ANY}};
      rxc(0, 1'b1, 1'b0, 1'b1, 16'h0000, 5'h1f);
      clr(0);
      op_mode = CMB_ENH;
      {receive_mode_field, filter_extended_enable} = '0;
      prog_tx_enable = 6'h10;
      filter_buffer_assoc = '1;
      filter_buffer_assoc[3] = 4'h2;
      filter_buffer_assoc[7] = 4'h5;
      filter_buffer_assoc[9] = 4'h6;
      rxc(2, 1'b0, 1'b0, 1'b0, 16'h0088, 5'd3);
      rxc(-1, 1'b0, 1'b0, 1'b0, 16'h0200, 5'h1f);
      chk_v("full", 8'h04, rx_buffer_full_flag);
      clr(2);
      // Type bit in the mask makes filter 3 standard-only
      mask_ident_type[3] = 1'b1;
      rxc(-1, 1'b1, 1'b0, 1'b0, 16'h0008, 5'h1f);
      chk_v("full", 8'h00, rx_buffer_full_flag);
      rxc(2, 1'b0, 1'b0, 1'b0, 16'h0008, 5'd3);
      clr(2);
      mask_ident_type = '0;
      op_mode = CMB_FIFO;
      prog_tx_enable = 6'h08;
      fw_hold = 1'b1;
      foreach (fb[i]) fb[i] = MSG_W'({$urandom, $urandom, $urandom, $urandom});
      fork
         for (int i = 0; i < 3; i++) node.send(fb[i], 1'b0, 1'b0, 1'b0, 16'h0100);
      join_none
      repeat (12) @(negedge clk_sys);
      // Two frames parked, the third must be refused
      chk_v("asm_ready", 8'h00, 8'(asm_ready));
      chk_v("full", 8'h00, rx_buffer_full_flag);
      fw_hold = 1'b0;
      repeat (10) @(negedge clk_sys);
      exp_ld += 3;
      for (int i = 0; i < 3; i++) begin
         view(i);
         chk_b("fifo_body", fb[i], rd_body);
      end
      chk_v("icode", 8'(ICODE_FIFO), 8'(interrupt_code_field));
      chk_n("wm", 0, wm_n);
      rxc(3, 1'b0, 1'b0, 1'b0, 16'h0100, 5'd8);
      chk_n("wm", 1, wm_n);
      rxc(4, 1'b0, 1'b0, 1'b0, 16'h0100, 5'd8);
      chk_n("wm", 1, wm_n);
      chk_v("full", 8'h1f, rx_buffer_full_flag);
      chk_v("rd_ptr", 8'h00, 8'(fifo_read_pointer));
      clr(0);
      chk_v("rd_ptr", 8'h01, 8'(fifo_read_pointer));
      rxc(0, 1'b0, 1'b0, 1'b0, 16'h0100, 5'd8);
      for (int i = 1; i < 5; i++) clr(i);
      chk_v("rd_ptr", 8'h00, 8'(fifo_read_pointer));
      chk_v("full", 8'h01, rx_buffer_full_flag);
      chk_n("irq", exp_ld, irq_n);
      chk_n("trig", exp_ld, trig_n);
      print_verdict();
   end
endmodule // tb_can_msg_buffer_rx_tx_priority
